// ===== hw/dpm_top.sv
// Debug probe multiplexer: routes internal signals to probe pins or DACs.
// Assumes an APB master on REF_CLK and group signals synchronous to it.
//
// Notes on behaviour
// R01: Two analog or four digital probes, not both
// R02: Probes work only with enable setting set
// R03: Separate commands for digital and analog probes
// R04: Digital command first byte picks signal group
// R05: Group codes 01,1B,1D,30,58,70,73 decode to groups
// R06: Low nibble picks signal; 8 is 13.56 MHz
// R07: High nibble picks pin 0..3; others reserved
// R08: Clock group signals at selections 0..7
// R09: Transmit group: 0 interrupt, 1 envelope
// R10: Timer group: 7..2 running/expired per timer
// R11: Card-mode group signals at selections 0..7
// R12: Transceive group signals at selections 0..7
// R13: Receive data group signals at selections 0..7
// R14: Receive error group: 7,6,2,1,0; 3..5 reserved
// R15: Pin choice held in position setting bits 7:4
// R16: Analog probes stream processor data to two DACs
// R17: Analog command's two parameters choose DAC sources
// R18: Reserved choices leave pin in normal function
`timescale 1ns/1ps
module dpm_top (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CLK1356_SIG,
  input wire logic [7:0] CLOCK_GRP_SIG,
  input wire logic [1:0] TXENC_GRP_SIG,
  input wire logic [5:0] TIMER_GRP_SIG,
  input wire logic [7:0] CARD_GRP_SIG,
  input wire logic [7:0] XCV_GRP_SIG,
  input wire logic [7:0] RXDAT_GRP_SIG,
  input wire logic [4:0] RXERR_GRP_SIG,
  input wire logic [63:0] SIGNAL_PROCESSOR_SRC_DATA,
  output logic [3:0] PROBE_PIN_OVR,
  output logic [3:0] PROBE_PIN_OUT,
  output logic [1:0] DAC_ACTIVE,
  output logic [7:0] DAC1_DATA,
  output logic [7:0] DAC2_DATA,
  output logic [1:0] PROBE_MODE
);
  import dpm_pkg::*;
  `include "dpm_defs.svh"

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic dpm_group_t decode_group(input logic [7:0] code);
    dpm_group_t g;
    g = DPM_G_NONE;
    if (code == `DPM_CODE_CLOCK) begin
      g = DPM_G_CLOCK;
    end else if (code == `DPM_CODE_TXENC) begin
      g = DPM_G_TXENC;
    end else if (code == `DPM_CODE_TIMER) begin
      g = DPM_G_TIMER;
    end else if (code == `DPM_CODE_CARD) begin
      g = DPM_G_CARD;
    end else if (code == `DPM_CODE_XCV) begin
      g = DPM_G_XCV;
    end else if (code == `DPM_CODE_RXDAT) begin
      g = DPM_G_RXDAT;
    end else if (code == `DPM_CODE_RXERR) begin
      g = DPM_G_RXERR;
    end
    return g;
  endfunction

  // Valid selections per group; 8 is legal in every group but DPM_G_NONE
  function automatic logic sel_valid(input dpm_group_t g,
                                     input logic [3:0] sel);
    logic ok;
    ok = 1'b0;
    if (g != DPM_G_NONE && sel == `DPM_SEL_CLK1356) begin
      ok = 1'b1; // R06
    end else if (sel[3] == 1'b0) begin
      case (g)
        DPM_G_NONE: ok = 1'b0;
        DPM_G_TXENC: ok = (sel < 4'h2); // R09
        DPM_G_TIMER: ok = (sel > 4'h1); // R10
        DPM_G_RXERR: ok = (sel < 4'h3) || (sel > 4'h5); // R14
        default: ok = 1'b1;
      endcase
    end
    return ok;
  endfunction

  // Source word for an analog selector; code 0 means DAC off
  function automatic logic [7:0] dac_word(input logic [7:0] src,
                                          input logic [63:0] bus);
    return bus[src[2:0]*8 +: 8];
  endfunction

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  logic probe_output_enable;
  logic cmd_refused;
  logic [7:0] probe_position_setting;
  logic [7:0] dac1_src;
  logic [7:0] dac2_src;
  dpm_mode_t mode;
  logic [6:0] tbl_rdata;
  logic [27:0] tbl_entries;

  wire setup_phase = PSEL && !PENABLE;
  wire access_done = PSEL && PENABLE && PREADY;
  wire wr_done = access_done && PWRITE;
  wire hit_enable = (PADDR == `DPM_OFS_ENABLE);
  wire hit_digcmd = (PADDR == `DPM_OFS_DIGCMD);
  wire hit_anacmd = (PADDR == `DPM_OFS_ANACMD);
  wire hit_status = (PADDR == `DPM_OFS_STATUS);
  wire hit_pincfg = ((PADDR & `DPM_PINCFG_MASK) == `DPM_OFS_PINCFG) &&
                    (PADDR[1:0] == 2'b00);
  wire addr_ok = hit_enable || hit_digcmd || hit_anacmd || hit_status ||
                 hit_pincfg;
  wire [1:0] pin_index = PADDR[3:2];

  logic [31:0] read_mux;
  always_comb begin
    read_mux = 32'h0000_0000;
    if (hit_enable) begin
      read_mux[`DPM_ENABLE_BIT] = probe_output_enable;
    end else if (hit_anacmd) begin
      read_mux[15:0] = {dac2_src, dac1_src};
    end else if (hit_status) begin
      read_mux[7:0] = probe_position_setting;
      read_mux[`DPM_STATUS_REFUSED_BIT] = cmd_refused;
      read_mux[`DPM_STATUS_MODE_LSB +: 2] = mode;
    end else if (hit_pincfg) begin
      read_mux[6:0] = tbl_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // APB slave: one wait state, answer in the second access cycle
  // ----------------------------------------------------------------------
  // The wait state lets the table's registered read catch up.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && PENABLE && !PREADY;
      if (PSEL && PENABLE && !PREADY) begin
        PRDATA <= PWRITE ? 32'h0000_0000 : read_mux;
        PSLVERR <= !addr_ok;
      end else if (setup_phase) begin
        PSLVERR <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  wire [7:0] param1 = PWDATA[`DPM_PARAM1_LSB +: 8];
  wire [7:0] param2 = PWDATA[`DPM_PARAM2_LSB +: 8];
  wire dpm_group_t cmd_group = decode_group(param1); // R04 R05
  wire [3:0] cmd_sel = param2[3:0]; // R06
  wire [3:0] cmd_pin = param2[7:4]; // R07
  wire pin_ok = (cmd_pin < 4'h4); // R07
  wire choice_ok = sel_valid(cmd_group, cmd_sel);
  wire dig_cmd = wr_done && hit_digcmd; // R03
  wire ana_cmd = wr_done && hit_anacmd; // R03
  wire accept_dig = dig_cmd && probe_output_enable; // R02
  wire accept_ana = ana_cmd && probe_output_enable; // R02
  // Reserved group or signal clears the pin entry so it reverts
  wire tbl_we = accept_dig && pin_ok; // R18
  wire [6:0] tbl_wdata = choice_ok ? {cmd_group, cmd_sel} : `DPM_RST_ENTRY;

  // ----------------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------------
  dpm_mode_t next_mode;
  always_comb begin
    next_mode = mode;
    if (!probe_output_enable) begin
      next_mode = DPM_MODE_OFF; // R02
    end else if (accept_dig) begin
      next_mode = DPM_MODE_DIGITAL; // R01
    end else if (accept_ana) begin
      next_mode = DPM_MODE_ANALOG; // R01
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      probe_output_enable <= `DPM_RST_ENABLE;
      mode <= DPM_MODE_OFF;
      cmd_refused <= 1'b0;
      probe_position_setting <= `DPM_RST_POSITION;
      dac1_src <= `DPM_RST_DACSRC;
      dac2_src <= `DPM_RST_DACSRC;
    end else begin
      mode <= next_mode;
      if (wr_done && hit_enable) begin
        probe_output_enable <= PWDATA[`DPM_ENABLE_BIT]; // R02
      end
      if (dig_cmd || ana_cmd) begin
        cmd_refused <= !probe_output_enable; // R02
      end
      if (accept_dig) begin
        probe_position_setting <= param2; // R15
      end
      if (accept_ana) begin
        dac1_src <= param1; // R17
        dac2_src <= param2; // R17
      end
    end
  end

  dpm_pin_table u_table (
    .clk(REF_CLK),
    .rst(RST),
    .we(tbl_we),
    .waddr(cmd_pin[1:0]),
    .wdata(tbl_wdata),
    .raddr(pin_index),
    .rdata(tbl_rdata),
    .entries(tbl_entries)
  );

  // ----------------------------------------------------------------------
  // Group signal vectors, reserved positions tied low
  // ----------------------------------------------------------------------
  wire [7:0] grp_bits [8];
  assign grp_bits[DPM_G_NONE] = 8'h00;
  assign grp_bits[DPM_G_CLOCK] = CLOCK_GRP_SIG; // R08
  assign grp_bits[DPM_G_TXENC] = {6'h00, TXENC_GRP_SIG}; // R09
  assign grp_bits[DPM_G_TIMER] = {TIMER_GRP_SIG, 2'h0}; // R10
  assign grp_bits[DPM_G_CARD] = CARD_GRP_SIG; // R11
  assign grp_bits[DPM_G_XCV] = XCV_GRP_SIG; // R12
  assign grp_bits[DPM_G_RXDAT] = RXDAT_GRP_SIG; // R13
  assign grp_bits[DPM_G_RXERR] = {RXERR_GRP_SIG[4:3], 3'h0,
                                  RXERR_GRP_SIG[2:0]}; // R14

  // ----------------------------------------------------------------------
  // Per-pin digital mux, four pins in parallel
  // ----------------------------------------------------------------------
  wire digital_on = (mode == DPM_MODE_DIGITAL);
  logic [3:0] next_pin_ovr;
  logic [3:0] next_pin_out;
  always_comb begin
    dpm_group_t g;
    logic [3:0] s;
    g = DPM_G_NONE;
    s = 4'h0;
    next_pin_ovr = 4'h0;
    next_pin_out = 4'h0;
    for (int p = 0; p < `DPM_PIN_COUNT; p++) begin
      g = dpm_group_t'(tbl_entries[p*7+4 +: 3]);
      s = tbl_entries[p*7 +: 4];
      next_pin_ovr[p] = digital_on && (g != DPM_G_NONE); // R01 R18
      if (!next_pin_ovr[p]) begin
        next_pin_out[p] = 1'b0;
      end else if (s == `DPM_SEL_CLK1356) begin
        next_pin_out[p] = CLK1356_SIG; // R06
      end else begin
        next_pin_out[p] = grp_bits[g][s[2:0]];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Analog path: two DACs fed from processor words in real time
  // ----------------------------------------------------------------------
  // One register stage of latency; the DAC sees every new word.
  wire analog_on = (mode == DPM_MODE_ANALOG);
  wire dac1_on = analog_on && (dac1_src[2:0] != 3'h0); // R16
  wire dac2_on = analog_on && (dac2_src[2:0] != 3'h0); // R16

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      PROBE_PIN_OVR <= 4'h0;
      PROBE_PIN_OUT <= 4'h0;
      DAC_ACTIVE <= 2'h0;
      DAC1_DATA <= 8'h00;
      DAC2_DATA <= 8'h00;
      PROBE_MODE <= 2'h0;
    end else begin
      PROBE_PIN_OVR <= next_pin_ovr;
      PROBE_PIN_OUT <= next_pin_out;
      DAC_ACTIVE <= {dac2_on, dac1_on}; // R01
      DAC1_DATA <= dac1_on ? dac_word(dac1_src, SIGNAL_PROCESSOR_SRC_DATA) : 8'h00;
      DAC2_DATA <= dac2_on ? dac_word(dac2_src, SIGNAL_PROCESSOR_SRC_DATA) : 8'h00;
      // Follows mode so it lines up with the pin and converter outputs
      PROBE_MODE <= mode; // R01
    end
  end

endmodule // dpm_top

// ===== hw/dpm_defs.svh
// Debug probe multiplexer: register offsets, field positions, codes.
// Assumes inclusion by bare name from any file that needs the numbers.
`ifndef DPM_DEFS_SVH
`define DPM_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define DPM_OFS_ENABLE 8'h00
`define DPM_OFS_DIGCMD 8'h04
`define DPM_OFS_ANACMD 8'h08
`define DPM_OFS_STATUS 8'h0C
`define DPM_OFS_PINCFG 8'h10
`define DPM_PINCFG_MASK 8'hF0

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define DPM_ENABLE_BIT 0
`define DPM_PARAM1_LSB 0
`define DPM_PARAM2_LSB 8
`define DPM_STATUS_REFUSED_BIT 8
`define DPM_STATUS_MODE_LSB 12
`define DPM_NV_ENABLE_ADDR 8'h17

// ----------------------------------------------------------------------
// Group codes of the digital probe command
// ----------------------------------------------------------------------
`define DPM_CODE_CLOCK 8'h01
`define DPM_CODE_TXENC 8'h1B
`define DPM_CODE_TIMER 8'h1D
`define DPM_CODE_CARD 8'h30
`define DPM_CODE_XCV 8'h58
`define DPM_CODE_RXDAT 8'h70
`define DPM_CODE_RXERR 8'h73

// ----------------------------------------------------------------------
// Selection values and reset values
// ----------------------------------------------------------------------
`define DPM_SEL_CLK1356 4'h8
`define DPM_PIN_COUNT 4
`define DPM_RST_ENABLE 1'b0
`define DPM_RST_POSITION 8'h00
`define DPM_RST_DACSRC 8'h00
`define DPM_RST_ENTRY 7'h00

`endif

// ===== hw/dpm_pkg.sv
// Debug probe multiplexer types shared by the design files.
// Assumes nothing of its surroundings.
package dpm_pkg;

  // ----------------------------------------------------------------------
  // Signal groups, NONE marks a pin that keeps its normal function
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    DPM_G_NONE,
    DPM_G_CLOCK,
    DPM_G_TXENC,
    DPM_G_TIMER,
    DPM_G_CARD,
    DPM_G_XCV,
    DPM_G_RXDAT,
    DPM_G_RXERR
  } dpm_group_t;

  // ----------------------------------------------------------------------
  // Probe mode
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    DPM_MODE_OFF,
    DPM_MODE_DIGITAL,
    DPM_MODE_ANALOG
  } dpm_mode_t;

endpackage

// ===== hw/dpm_pin_table.sv
// Per-pin probe selection store: four entries of group and selection.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module dpm_pin_table (
  input wire logic clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [1:0] waddr,
  input wire logic [6:0] wdata,
  input wire logic [1:0] raddr,
  output logic [6:0] rdata,
  output logic [27:0] entries
);
  `include "dpm_defs.svh"

  // ----------------------------------------------------------------------
  // Storage, all words visible so every pin can mux in parallel
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      entries <= {`DPM_PIN_COUNT{`DPM_RST_ENTRY}};
    end else if (we) begin
      entries[waddr*7 +: 7] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= `DPM_RST_ENTRY;
    end else begin
      rdata <= entries[raddr*7 +: 7];
    end
  end

endmodule // dpm_pin_table

// ===== dv/dpm_scope.sv
// Partner model: a logic analyser watching the four probe pins.
// Assumes the probe pins are sampled on the device clock.
`timescale 1ns/1ps
module dpm_scope (
  input wire logic clk,
  input wire logic [3:0] pin_ovr,
  input wire logic [3:0] pin_out,
  output logic [3:0] seen
);
  // A pin in its normal function reads as low on the analyser
  always_ff @(posedge clk) begin
    seen <= pin_out & pin_ovr;
  end
endmodule // dpm_scope

// ===== dv/dpm_top_properties.sv
// Concurrent checks on the ports of the debug probe multiplexer.
// Assumes binding to dpm_top; single clock, synchronous reset.
`timescale 1ns/1ps
module dpm_top_properties (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [3:0] PROBE_PIN_OVR,
  input wire logic [3:0] PROBE_PIN_OUT,
  input wire logic [1:0] DAC_ACTIVE,
  input wire logic [7:0] DAC1_DATA,
  input wire logic [7:0] DAC2_DATA,
  input wire logic [1:0] PROBE_MODE
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // ----------------------------------------------------------------------
  // Bus phases
  // ----------------------------------------------------------------------
  sequence s_setup; PSEL && !PENABLE; endsequence
  sequence s_access; PSEL && PENABLE; endsequence
  sequence s_commit; PSEL && PENABLE && PREADY && PWRITE; endsequence
  AST_ONE_WAIT: assert property (s_setup ##1 s_access |-> !PREADY ##1 PREADY)
    else $error("ready not in second access cycle");
  AST_READY_PULSE: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  AST_UNMAPPED: assert property (PREADY && (PADDR > 8'h1C || PADDR[1:0] != 2'h0)
    |-> PSLVERR)
    else $error("unmapped access not flagged");
  AST_DISABLE_OFF: assert property (s_commit and (PADDR == 8'h00 && !PWDATA[0])
    |-> ##[1:3] PROBE_MODE == 2'h0)
    else $error("probes stay on after disable");
  // ----------------------------------------------------------------------
  // Probe outputs
  // ----------------------------------------------------------------------
  AST_OVR_GATES_OUT: assert property ((PROBE_PIN_OUT & ~PROBE_PIN_OVR) == 4'h0)
    else $error("probe value on a pin in normal function");
  AST_DIGITAL_ONLY: assert property (PROBE_MODE != 2'h1 |-> PROBE_PIN_OVR == 4'h0)
    else $error("digital pins active outside digital mode");
  AST_ANALOG_ONLY: assert property (PROBE_MODE != 2'h2 |-> DAC_ACTIVE == 2'h0)
    else $error("converters active outside analog mode");
  AST_DAC_IDLE: assert property ((!DAC_ACTIVE[0] -> DAC1_DATA == 8'h00)
    && (!DAC_ACTIVE[1] -> DAC2_DATA == 8'h00))
    else $error("idle converter word not zero");
  AST_MODE_CODE: assert property (PROBE_MODE != 2'h3)
    else $error("illegal probe mode");
endmodule // dpm_top_properties

bind dpm_top dpm_top_properties dpm_top_properties_inst (.REF_CLK, .RST,
  .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PREADY, .PSLVERR,
  .PROBE_PIN_OVR, .PROBE_PIN_OUT, .DAC_ACTIVE, .DAC1_DATA, .DAC2_DATA,
  .PROBE_MODE);

// ===== dv/dpm_top_bench.sv
// Self-checking bench for the debug probe multiplexer.
// Assumes design files, dpm_scope and the checker compiled before it.
`timescale 1ns/1ps
module dpm_top_bench;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, clk1356 = 0;
  logic [7:0] paddr = 0, clk_g = 0, card_g = 0, xcv_g = 0, rxd_g = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [1:0] tx_g = 0, dact, mode;
  logic [5:0] tim_g = 0;
  logic [4:0] rxe_g = 0;
  logic [63:0] spd = 0;
  logic [3:0] ovr, pout, seen;
  logic [7:0] d1, d2;
  logic pready, pslverr, er;
  int error_cnt = 0, num_checks = 0, cyc = 0;
  int eg[4] = '{0, 0, 0, 0}, es[4] = '{0, 0, 0, 0};
  int en = 0, md = 0, pos = 0, refd = 0, a1, a2;
  int codes[8] = '{8'h01, 8'h1B, 8'h1D, 8'h30, 8'h58, 8'h70, 8'h73, 8'h42};

  initial forever #2.5 clk = ~clk;

  dpm_top dpm_top_inst (.REF_CLK(clk), .RST(rst), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CLK1356_SIG(clk1356), .CLOCK_GRP_SIG(clk_g), .TXENC_GRP_SIG(tx_g),
    .TIMER_GRP_SIG(tim_g), .CARD_GRP_SIG(card_g), .XCV_GRP_SIG(xcv_g),
    .RXDAT_GRP_SIG(rxd_g), .RXERR_GRP_SIG(rxe_g), .SIGNAL_PROCESSOR_SRC_DATA(spd),
    .PROBE_PIN_OVR(ovr), .PROBE_PIN_OUT(pout), .DAC_ACTIVE(dact),
    .DAC1_DATA(d1), .DAC2_DATA(d2), .PROBE_MODE(mode));
  dpm_scope dpm_scope_inst (.clk(clk), .pin_ovr(ovr), .pin_out(pout),
    .seen(seen));

  // ----------------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] sv, input logic [31:0] ev);
    num_checks++;
    if (sv !== ev) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, sv, ev);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Waits on the slave's answer; only the global timeout bounds a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    pen <= 0;
  endtask

  // ----------------------------------------------------------------------
  // Reference model of the routing
  // ----------------------------------------------------------------------
  function automatic bit ok(int g, int s);
    if (g == 0 || s > 8) return 0;
    if (s == 8) return 1;
    case (g)
      2: return s < 2;
      3: return s > 1;
      7: return s < 3 || s > 5;
      default: return 1;
    endcase
  endfunction

  function automatic logic sig(int g, int s);
    if (s == 8) return clk1356;
    case (g)
      1: return clk_g[s];
      2: return tx_g[s];
      3: return tim_g[s-2];
      4: return card_g[s];
      5: return xcv_g[s];
      6: return rxd_g[s];
      default: return rxe_g[s < 3 ? s : s - 3];
    endcase
  endfunction

  task automatic shake;
    @(posedge clk);
    {clk_g, card_g, xcv_g, rxd_g} <= $urandom;
    {tx_g, tim_g, rxe_g, clk1356} <= 14'($urandom);
    spd <= {$urandom, $urandom};
  endtask

  task automatic pins;
    logic [3:0] eo;
    logic [3:0] ev;
    eo = 0;
    ev = 0;
    repeat (4) @(posedge clk);
    for (int p = 0; p < 4; p++) begin
      if (md == 1 && eg[p] != 0) begin
        eo[p] = 1;
        ev[p] = sig(eg[p], es[p]);
      end
    end
    chk(ovr, eo);
    chk(pout, ev);
    chk(seen, ev);
    chk(mode, md);
  endtask

  task automatic dig(input int code, input int g, input int s, input int p);
    apb(1, 8'h04, {16'h0, 4'(p), 4'(s), 8'(code)});
    if (en == 0) refd = 1;
    else begin
      refd = 0;
      pos = p * 16 + s;
      md = 1;
      if (p < 4) eg[p] = ok(g, s) ? g : 0;
      if (p < 4) es[p] = ok(g, s) ? s : 0;
    end
    pins;
    apb(0, 8'h0C, 0);
    chk(rd, {18'h0, 2'(md), 3'h0, 1'(refd), 8'(pos)});
    if (p < 4) apb(0, 8'(16 + 4 * p), 0);
    if (p < 4) chk(rd, eg[p] * 16 + es[p]);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence and timeout
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(32'h1aed));
    repeat (5) @(posedge clk);
    rst <= 0;
    for (int a = 0; a < 32; a += 4) begin
      apb(0, 8'(a), 0);
      chk(rd, 0);
      chk(er, 0);
    end
    pins;
    dig(8'h01, 1, 3, 0);
    apb(1, 8'h00, 1);
    en = 1;
    apb(0, 8'h00, 0);
    chk(rd, 1);
    for (int i = 0; i < 48; i++) begin
      shake;
      dig(codes[i%8], i % 8 < 7 ? i % 8 + 1 : 0, i < 8 ? 8 : $urandom % 11,
        i < 8 ? i % 4 : $urandom % 5);
      shake;
      pins;
    end
    apb(1, 8'h20, 32'hFF);
    chk(er, 1);
    apb(0, 8'h20, 0);
    chk(er, 1);
    chk(rd, 0);
    for (int i = 0; i < 6; i++) begin
      shake;
      a1 = (i == 0) ? 0 : $urandom % 8;
      a2 = $urandom % 8;
      apb(1, 8'h08, {16'h0, 8'(a2), 8'(a1)});
      md = 2;
      pins;
      chk(dact, {a2 != 0, a1 != 0});
      chk(d1, a1 != 0 ? spd[8*a1+:8] : 8'h00);
      chk(d2, a2 != 0 ? spd[8*a2+:8] : 8'h00);
      apb(0, 8'h08, 0);
      chk(rd, a2 * 256 + a1);
    end
    dig(8'h01, 1, 0, 1);
    apb(1, 8'h00, 0);
    en = 0;
    md = 0;
    pins;
    chk(dact, 0);
    dig(8'h1B, 2, 1, 2);
    stop_test;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test;
    end
  end
endmodule // dpm_top_bench
